// File: hw/eeprom_cells.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// Cell storage: 512 array bytes plus the configuration byte
// ------------------------------------------------------------
module eeprom_cells
    import eeprom_pkg::*;
(
    input  wire logic            pclk,
    input  wire cell_req_t       req,
    output logic      [7:0]      rdata
);

    logic [7:0] cells [CELL_DEPTH];
    logic [7:0] rdata_ff;

    // Nonvolatile content: no reset on purpose
    always_ff @(posedge pclk) begin
        if (req.we) begin
            cells[req.addr] <= req.wdata;
        end
        rdata_ff <= cells[req.addr];
    end

    assign rdata = rdata_ff;

endmodule : eeprom_cells

`default_nettype wire

// File: hw/eeprom_pkg.sv
package eeprom_pkg;

    // ------------------------------------------------------------
    // Bus and register map (printed offsets are word indexes)
    // ------------------------------------------------------------
    localparam int          ADDR_W         = 18;
    localparam logic [15:0] IDX_EEPROM_BLOCK_PROTECT      = 16'h1035;
    localparam logic [15:0] IDX_EEPROM_PROGRAM_CONTROL      = 16'h103B;
    localparam logic [15:0] IDX_CONFIG     = 16'h103F;
    localparam logic [15:0] IDX_ARRAY_BASE = 16'hFE00;
    localparam int          ARRAY_IDX_MSB  = 15;
    localparam int          ARRAY_IDX_LSB  = 9;

    // ------------------------------------------------------------
    // Cell array geometry
    // ------------------------------------------------------------
    localparam int          CELL_AW        = 10;
    localparam int          CELL_DEPTH     = 513;
    localparam logic [9:0]  CFG_CELL       = 10'h200;
    localparam logic [9:0]  LAST_ARRAY     = 10'h1FF;
    localparam logic [9:0]  ROW_MASK       = 10'h00F;
    localparam logic [9:0]  REGION0_END    = 10'h020;
    localparam logic [9:0]  REGION1_END    = 10'h060;
    localparam logic [9:0]  REGION2_END    = 10'h0E0;
    localparam logic [7:0]  ERASED_BYTE    = 8'hFF;

    // ------------------------------------------------------------
    // Protect register fields and reset
    // ------------------------------------------------------------
    localparam int          PROT_W         = 5;
    localparam int          PROT_CFG_BIT   = 4;
    localparam logic [4:0]  EEPROM_BLOCK_PROTECT_RESET    = 5'h1F;
    localparam logic [6:0]  EARLY_CYCLES   = 7'h40;

    // ------------------------------------------------------------
    // Program control fields and reset
    // ------------------------------------------------------------
    localparam int          PP_ODD         = 7;
    localparam int          PP_EVEN        = 6;
    localparam int          PP_BYTE        = 4;
    localparam int          PP_ROW         = 3;
    localparam int          PP_ERASE       = 2;
    localparam int          PP_LATCH       = 1;
    localparam int          PP_HV          = 0;
    localparam logic [7:0]  EEPROM_PROGRAM_CONTROL_RESET    = 8'h00;

    typedef struct packed {
        logic odd;
        logic even;
        logic byte_sel;
        logic row_sel;
        logic erase;
        logic latch_mode;
        logic high_voltage_on;
    } eeprom_program_control_t;

    typedef struct packed {
        logic       we;
        logic [9:0] addr;
        logic [7:0] wdata;
    } cell_req_t;

    typedef enum logic [1:0] {
        ST_LOAD   = 2'b00,
        ST_IDLE   = 2'b01,
        ST_RDWAIT = 2'b10,
        ST_SWEEP  = 2'b11
    } ctl_state_t;

endpackage : eeprom_pkg

// File: hw/eeprom_program_erase_control.sv
// Behaviour
// - protect bits clear only first 64 cycles or in special mode
// - protect bit set stays set until reset
// - config-protect blocks config program and erase
// - four protect bits guard 32/64/128/288-byte regions
// - protection never affects reads
// - latch plus high voltage at once sets neither
// - EEPROM writes ignored while high voltage on
// - no latched address means no operation
// - latch clear gives plain array reads
// - latch set captures address and data
// - high voltage writable only while latch set
// - high voltage bit drives the pump
// - erase bit selects erase or program
// - byte, row or bulk erase sizes
// - program ignores byte and row bits
// - control bit 5 reads zero
// - config bulk erase also erases array
// - new config value active after reset
`timescale 1ns/100ps
`default_nettype none

module eeprom_program_erase_control
    import eeprom_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic              special_mode_pin,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   pump_enable,
    output logic      [7:0]        config_active
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    ctl_state_t         state_ff;
    logic               mode_meta_ff, mode_sync_ff;
    logic [6:0]         early_cnt_ff;
    logic [PROT_W-1:0]  eeprom_block_protect_ff, sw_set_ff, nxt_eeprom_block_protect;
    eeprom_program_control_t             eeprom_program_control_ff, nxt_eeprom_program_control;
    logic [9:0]         lat_addr_ff, bus_cell;
    logic [7:0]         lat_data_ff, wd;
    logic               lat_valid_ff, armed_ff, load_seen_ff;
    logic               op_erase_ff, op_byte_ff, op_row_ff;
    logic [9:0]         sweep_ptr_ff, sweep_end_ff, nxt_start, nxt_end;
    logic [7:0]         sweep_data_ff, nxt_data;
    logic [31:0]        prdata_ff;
    logic               pready_ff, pslverr_ff;
    logic [7:0]         config_active_ff, cell_rdata;
    cell_req_t          cell_req;
    logic [15:0]        idx;
    logic               aligned, acc;
    logic               hit_eeprom_block_protect, hit_eeprom_program_control, hit_cfg, hit_array;
    logic               wr_eeprom_block_protect, wr_eeprom_program_control, wr_cell, rd_array;
    logic               hv_rise, hv_fall, early_open;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Only one access is served at a time; nothing new while busy
    assign idx       = paddr[ADDR_W-1:2];
    assign aligned   = (paddr[1:0] == 2'h0);
    assign wd        = pwdata[7:0];
    assign acc       = psel & penable & ~pready_ff & (state_ff == ST_IDLE);
    assign hit_eeprom_block_protect = aligned & (idx == IDX_EEPROM_BLOCK_PROTECT);
    assign hit_eeprom_program_control = aligned & (idx == IDX_EEPROM_PROGRAM_CONTROL);
    assign hit_cfg   = aligned & (idx == IDX_CONFIG);
    assign hit_array = aligned &
        (idx[ARRAY_IDX_MSB:ARRAY_IDX_LSB] == IDX_ARRAY_BASE[ARRAY_IDX_MSB:ARRAY_IDX_LSB]);
    assign bus_cell  = hit_cfg ? CFG_CELL : {1'b0, idx[8:0]};
    assign wr_eeprom_block_protect  = acc & pwrite & hit_eeprom_block_protect;
    assign wr_eeprom_program_control  = acc & pwrite & hit_eeprom_program_control;
    assign wr_cell   = acc & pwrite & (hit_array | hit_cfg);
    assign rd_array  = acc & ~pwrite & hit_array;

    // ------------------------------------------------------------
    // Protection lookup
    // ------------------------------------------------------------
    // Only the write side of the cells consults this
    function automatic logic is_protected(input logic [9:0]        a,
                                          input logic [PROT_W-1:0] p);
        logic r;
        r = 1'b0;
        if (a == CFG_CELL) begin
            r = p[PROT_CFG_BIT];
        end else if (a < REGION0_END) begin
            r = p[0];
        end else if (a < REGION1_END) begin
            r = p[1];
        end else if (a < REGION2_END) begin
            r = p[2];
        end else begin
            r = p[3];
        end
        return r;
    endfunction : is_protected

    // ------------------------------------------------------------
    // Mode pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_meta_ff <= 1'b0;
            mode_sync_ff <= 1'b0;
        end else begin
            mode_meta_ff <= special_mode_pin;
            mode_sync_ff <= mode_meta_ff;
        end
    end

    // ------------------------------------------------------------
    // Early window after reset
    // ------------------------------------------------------------
    // Saturates so the window never reopens without a reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            early_cnt_ff <= 7'h00;
        end else if (early_cnt_ff != EARLY_CYCLES) begin
            early_cnt_ff <= early_cnt_ff + 7'h01;
        end
    end

    assign early_open = (early_cnt_ff != EARLY_CYCLES) | mode_sync_ff;

    // ------------------------------------------------------------
    // Block protect register
    // ------------------------------------------------------------
    // Bits set by software are sticky; clearing is gated by time
    always_comb begin
        if (early_open) begin
            nxt_eeprom_block_protect = wd[PROT_W-1:0] | sw_set_ff;
        end else begin
            nxt_eeprom_block_protect = eeprom_block_protect_ff | wd[PROT_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eeprom_block_protect_ff  <= EEPROM_BLOCK_PROTECT_RESET;
            sw_set_ff <= '0;
        end else if (wr_eeprom_block_protect) begin
            eeprom_block_protect_ff  <= nxt_eeprom_block_protect;
            sw_set_ff <= sw_set_ff | wd[PROT_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Program control register
    // ------------------------------------------------------------
    always_comb begin
        nxt_eeprom_program_control.odd      = wd[PP_ODD];
        nxt_eeprom_program_control.even     = wd[PP_EVEN];
        nxt_eeprom_program_control.byte_sel = wd[PP_BYTE];
        nxt_eeprom_program_control.row_sel  = wd[PP_ROW];
        nxt_eeprom_program_control.erase    = wd[PP_ERASE];
        if (wd[PP_LATCH] & wd[PP_HV] & ~eeprom_program_control_ff.latch_mode) begin
            nxt_eeprom_program_control.latch_mode      = 1'b0;
            nxt_eeprom_program_control.high_voltage_on = 1'b0;
        end else begin
            nxt_eeprom_program_control.latch_mode      = wd[PP_LATCH];
            nxt_eeprom_program_control.high_voltage_on = eeprom_program_control_ff.latch_mode & wd[PP_HV];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eeprom_program_control_ff <= eeprom_program_control_t'(7'h00);
        end else if (wr_eeprom_program_control) begin
            eeprom_program_control_ff <= nxt_eeprom_program_control;
        end
    end

    assign hv_rise = wr_eeprom_program_control & ~eeprom_program_control_ff.high_voltage_on & nxt_eeprom_program_control.high_voltage_on;
    assign hv_fall = wr_eeprom_program_control & eeprom_program_control_ff.high_voltage_on & ~nxt_eeprom_program_control.high_voltage_on;

    // ------------------------------------------------------------
    // Address and data latch
    // ------------------------------------------------------------
    // Frozen while voltage is on so a stray write cannot retarget
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lat_addr_ff  <= 10'h000;
            lat_data_ff  <= 8'h00;
            lat_valid_ff <= 1'b0;
        end else if (!eeprom_program_control_ff.latch_mode) begin
            lat_valid_ff <= 1'b0;
        end else if (wr_cell && !eeprom_program_control_ff.high_voltage_on) begin
            lat_addr_ff  <= bus_cell;
            lat_data_ff  <= wd;
            lat_valid_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Operation arming
    // ------------------------------------------------------------
    // Mode bits are frozen at voltage on and used at voltage off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_ff    <= 1'b0;
            op_erase_ff <= 1'b0;
            op_byte_ff  <= 1'b0;
            op_row_ff   <= 1'b0;
        end else if (hv_rise) begin
            armed_ff    <= lat_valid_ff;
            op_erase_ff <= nxt_eeprom_program_control.erase;
            op_byte_ff  <= nxt_eeprom_program_control.byte_sel;
            op_row_ff   <= nxt_eeprom_program_control.row_sel;
        end else if (hv_fall) begin
            armed_ff    <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Sweep range for the pending operation
    // ------------------------------------------------------------
    always_comb begin
        nxt_start = lat_addr_ff;
        nxt_end   = lat_addr_ff;
        nxt_data  = ERASED_BYTE;
        if (!op_erase_ff) begin
            nxt_data = lat_data_ff;
        end else if (op_byte_ff) begin
            nxt_start = lat_addr_ff;
        end else if (op_row_ff) begin
            if (lat_addr_ff != CFG_CELL) begin
                nxt_start = lat_addr_ff & ~ROW_MASK;
                nxt_end   = lat_addr_ff | ROW_MASK;
            end
        end else begin
            nxt_start = 10'h000;
            nxt_end   = (lat_addr_ff == CFG_CELL) ? CFG_CELL : LAST_ARRAY;
        end
    end

    // ------------------------------------------------------------
    // Control state machine and sweep
    // ------------------------------------------------------------
    // Cells change only once the pump is switched off again
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff      <= ST_LOAD;
            sweep_ptr_ff  <= 10'h000;
            sweep_end_ff  <= 10'h000;
            sweep_data_ff <= 8'h00;
            load_seen_ff  <= 1'b0;
        end else begin
            unique case (state_ff)
                ST_LOAD: begin
                    load_seen_ff <= 1'b1;
                    if (load_seen_ff) begin
                        state_ff <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (hv_fall && armed_ff) begin
                        state_ff      <= ST_SWEEP;
                        sweep_ptr_ff  <= nxt_start;
                        sweep_end_ff  <= nxt_end;
                        sweep_data_ff <= nxt_data;
                    end else if (rd_array && !eeprom_program_control_ff.latch_mode) begin
                        state_ff <= ST_RDWAIT;
                    end
                end
                ST_RDWAIT: state_ff <= ST_IDLE;
                ST_SWEEP: begin
                    sweep_ptr_ff <= sweep_ptr_ff + 10'h001;
                    if (sweep_ptr_ff == sweep_end_ff) begin
                        state_ff <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Cell port request
    // ------------------------------------------------------------
    always_comb begin
        cell_req.we    = 1'b0;
        cell_req.addr  = bus_cell;
        cell_req.wdata = sweep_data_ff;
        if (state_ff == ST_SWEEP) begin
            cell_req.addr = sweep_ptr_ff;
            cell_req.we   = ~is_protected(sweep_ptr_ff, eeprom_block_protect_ff);
        end else if (state_ff == ST_LOAD) begin
            cell_req.addr = CFG_CELL;
        end
    end

    eeprom_cells u_cells (
        .pclk  (pclk),
        .req   (cell_req),
        .rdata (cell_rdata)
    );

    // ------------------------------------------------------------
    // Active configuration
    // ------------------------------------------------------------
    // Captured only at start-up, so reprogramming waits for reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_active_ff <= 8'h00;
        end else if (state_ff == ST_LOAD && load_seen_ff) begin
            config_active_ff <= cell_rdata;
        end
    end

    // ------------------------------------------------------------
    // APB response
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            if (state_ff == ST_RDWAIT) begin
                prdata_ff <= {24'h00_0000, cell_rdata};
                pready_ff <= 1'b1;
            end else if (acc && !(rd_array && !eeprom_program_control_ff.latch_mode)) begin
                pready_ff <= 1'b1;
                prdata_ff <= 32'h0000_0000;
                if (!pwrite && hit_eeprom_block_protect) begin
                    prdata_ff <= {27'h000_0000, eeprom_block_protect_ff};
                end else if (!pwrite && hit_eeprom_program_control) begin
                    prdata_ff <= {24'h00_0000, eeprom_program_control_ff.odd, eeprom_program_control_ff.even, 1'b0,
                                  eeprom_program_control_ff.byte_sel, eeprom_program_control_ff.row_sel, eeprom_program_control_ff.erase,
                                  eeprom_program_control_ff.latch_mode, eeprom_program_control_ff.high_voltage_on};
                end else if (!pwrite && hit_cfg) begin
                    prdata_ff <= {24'h00_0000, config_active_ff};
                end
                if (!(hit_eeprom_block_protect | hit_eeprom_program_control | hit_cfg | hit_array)) begin
                    pslverr_ff <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata        = prdata_ff;
    assign pready        = pready_ff;
    assign pslverr       = pslverr_ff;
    assign pump_enable   = eeprom_program_control_ff.high_voltage_on;
    assign config_active = config_active_ff;

endmodule : eeprom_program_erase_control

`default_nettype wire

// File: tb/eeprom_program_erase_control_assertions.sv
`timescale 1ns/100ps
`default_nettype none

module eeprom_program_erase_control_assertions
    import eeprom_pkg::*;
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              special_mode_pin,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              pump_enable,
    input wire logic [7:0]        config_active
);
    // ---------------------------------------
    // Helpers
    // ---------------------------------------
    logic [3:0] settle_ff;
    logic       ctl_wr;

    // Saturating age count; the config load is long over at the top
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_ff <= 4'h0;
        end else if (settle_ff != 4'hF) begin
            settle_ff <= settle_ff + 4'h1;
        end
    end

    assign ctl_wr = psel && penable && pwrite && (paddr == 18'h040EC);

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
    property p_answer_bound; psel && penable && !pready |-> ##[1:1000] pready; endproperty
    a_answer_bound: assert property (p_answer_bound) else $error("no answer in time");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
    property p_misaligned; pready && (paddr[1:0] != 2'b00) |-> pslverr; endproperty
    a_misaligned: assert property (p_misaligned) else $error("misaligned access not refused");
    property p_err_data; pslverr |-> (prdata == 32'h0); endproperty
    a_err_data: assert property (p_err_data) else $error("refused access returned data");
    property p_ctrl_read;
        pready && !pwrite && (paddr == 18'h040EC) |-> (prdata[31:8] == 24'h0) && !prdata[5];
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control unused bits not zero");
    property p_prot_read;
        pready && !pwrite && (paddr == 18'h040D4) |-> (prdata[31:5] == 27'h0);
    endproperty
    a_prot_read: assert property (p_prot_read) else $error("protect unused bits not zero");
    property p_pump_by_write; $changed(pump_enable) |-> $past(ctl_wr); endproperty
    a_pump_by_write: assert property (p_pump_by_write) else $error("pump moved alone");
    property p_pump_rise; $rose(pump_enable) |-> $past(pwdata[0]); endproperty
    a_pump_rise: assert property (p_pump_rise) else $error("pump on without bit 0");
    property p_cfg_stable; (settle_ff == 4'hF) |-> $stable(config_active); endproperty
    a_cfg_stable: assert property (p_cfg_stable) else $error("config moved in mid-run");
endmodule : eeprom_program_erase_control_assertions

bind eeprom_program_erase_control eeprom_program_erase_control_assertions u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .special_mode_pin(special_mode_pin), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pump_enable(pump_enable),
    .config_active(config_active));

`default_nettype wire

// File: tb/eeprom_program_erase_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module eeprom_program_erase_control_tb_top
    import eeprom_pkg::*;
;
    typedef struct packed {
        logic wr; logic [17:0] a; logic [7:0] d; logic [7:0] e; logic err;
    } row_t;

    localparam logic [17:0] PA = 18'h040D4;
    localparam logic [17:0] CA = 18'h040EC;
    localparam logic [17:0] FA = 18'h040FC;

    logic              pclk, presetn, psel, penable, pwrite, special_mode_pin;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata;
    logic              pready, pslverr, pump_enable;
    logic [7:0]        config_active;
    int                bad_count, num_checks;
    row_t              rows[$];

    eeprom_program_erase_control DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .special_mode_pin(special_mode_pin),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pump_enable(pump_enable),
        .config_active(config_active));

    // ---------------------------------------
    // Clock, checks and bus tasks
    // ---------------------------------------
    always #5 pclk = ~pclk; // 100 MHz bus, above the slow pump-clock limit

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input row_t r);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= r.wr;
        paddr   <= r.a;
        pwdata  <= {24'h0, r.d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 2000);
        if (n >= 2000) begin
            bad_count++;
            end_of_test();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        if (!r.wr) chk(prdata, {24'h0, r.e});
        chk({31'h0, pslverr}, {31'h0, r.err});
        @(posedge pclk);
    endtask : apb

    task automatic r(input logic w, input logic [17:0] a, input logic [7:0] d, input logic [7:0] e);
        rows.push_back('{w, a, d, e, 1'b0});
    endtask : r

    function automatic logic [17:0] ar(input logic [8:0] o);
        return 18'h3F800 + {7'h0, o, 2'b00};
    endfunction : ar

    // Full software sequence: latch, target write, high voltage, clear
    task automatic op(input logic [7:0] c, input logic [17:0] a, input logic [7:0] d);
        r(1, CA, c | 8'h02, 0); r(1, a, d, 0); r(1, CA, c | 8'h03, 0); r(1, CA, 8'h00, 0);
    endtask : op

    task automatic run(input string name);
        foreach (rows[i]) apb(rows[i]);
        rows.delete();
        $display("test %s done", name);
    endtask : run

    task automatic rst();
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask : rst

    // ---------------------------------------
    // Main sequence
    // ---------------------------------------
    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
        pwdata = '0; special_mode_pin = 0; bad_count = 0; num_checks = 0;
        rst();
        r(1, PA, 8'h00, 0); r(0, PA, 0, 8'h00);
        r(1, CA, 8'hFF, 0); r(0, CA, 0, 8'hDC); r(1, CA, 8'h00, 0);
        r(1, CA, 8'h01, 0); r(0, CA, 0, 8'h00);
        op(8'h06, ar(9'h005), 8'h00); r(0, ar(9'h000), 0, 8'hFF); r(0, ar(9'h1FF), 0, 8'hFF);
        r(1, CA, 8'h1A, 0); r(1, ar(9'h005), 8'h5A, 0); r(1, CA, 8'h1B, 0);
        r(1, ar(9'h005), 8'hA5, 0); r(1, CA, 8'h00, 0);
        r(0, ar(9'h005), 0, 8'h5A); r(0, ar(9'h004), 0, 8'hFF);
        op(8'h00, ar(9'h010), 8'h33); op(8'h00, ar(9'h020), 8'h44); op(8'h0E, ar(9'h013), 8'h00);
        r(0, ar(9'h010), 0, 8'hFF); r(0, ar(9'h020), 0, 8'h44);
        op(8'h16, ar(9'h005), 8'h00); r(0, ar(9'h005), 0, 8'hFF);
        r(1, CA, 8'h02, 0); r(1, CA, 8'h03, 0); r(1, CA, 8'h00, 0); r(0, ar(9'h005), 0, 8'hFF);
        r(1, CA, 8'h02, 0); r(0, ar(9'h004), 0, 8'h00); r(1, CA, 8'h00, 0);
        r(0, ar(9'h004), 0, 8'hFF);
        rows.push_back('{1'b0, 18'h00010, 8'h00, 8'h00, 1'b1});
        rows.push_back('{1'b1, 18'h040ED, 8'h1C, 8'h00, 1'b1});
        r(0, CA, 0, 8'h00);
        op(8'h16, FA, 8'h00); op(8'h00, FA, 8'hA5);
        r(1, PA, 8'h01, 0); op(8'h00, ar(9'h01F), 8'h11); op(8'h00, ar(9'h020), 8'h22);
        r(0, ar(9'h01F), 0, 8'hFF); r(0, ar(9'h020), 0, 8'h22);
        r(1, PA, 8'h00, 0); r(0, PA, 0, 8'h01);
        run("table");
        r(1, CA, 8'h02, 0); r(1, CA, 8'h03, 0); run("pump on");
        chk({31'h0, pump_enable}, 32'h1);
        r(1, CA, 8'h00, 0); run("pump off");
        chk({31'h0, pump_enable}, 32'h0);
        rst();
        chk({24'h0, config_active}, 32'hA5);
        repeat (70) @(posedge pclk);
        r(1, PA, 8'h00, 0); r(0, PA, 0, 8'h1F);
        op(8'h00, FA, 8'h3C); op(8'h00, ar(9'h005), 8'h00); r(0, ar(9'h005), 0, 8'hFF);
        run("late protect");
        // Special mode reopens clearing; wait out the pin synchroniser
        special_mode_pin <= 1'b1;
        repeat (3) @(posedge pclk);
        r(1, PA, 8'h00, 0); r(0, PA, 0, 8'h00); run("special mode");
        special_mode_pin <= 1'b0;
        rst();
        chk({24'h0, config_active}, 32'hA5);
        $display("test reset done");
        end_of_test();
    end
endmodule : eeprom_program_erase_control_tb_top

`default_nettype wire
